// ===== sfptp_board.sv
// Board model: a driven pin shows the block's level, else the board's
`timescale 1ns/1ps
`default_nettype none
module sfptp_board (
   // Block drivers
   input wire logic [7:0] j_out, j_oe, k_out, k_oe, t_out, t_oe,
   // Board levels
   input wire logic [7:0] ext_j, ext_k, ext_g, ext_h,
   // Pin levels
   output logic [7:0] j_pin, k_pin, g_pin, h_pin
);
   assign j_pin = j_oe & j_out | ~j_oe & ext_j;
   assign k_pin = k_oe & k_out | ~k_oe & ext_k;
   assign g_pin = ext_g;
   assign h_pin = t_oe & t_out | ~t_oe & ext_h;
endmodule
`default_nettype wire

// ===== sfptp_monitor.sv
// Checker for the port and pass-through block
`timescale 1ns/1ps
`default_nettype none
module sfptp_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Register access
   input wire sfptp_pkg::sfptp_sfr_req_s sfr_req,
   input wire sfptp_pkg::sfptp_mem_req_s mem_req,
   input wire logic [7:0] mem_rdata,
   // Pins
   input wire logic [7:0] port_j_out,
   input wire logic [7:0] port_j_oe,
   input wire logic [7:0] port_k_oe,
   input wire logic [7:0] pass_source_pin_in,
   input wire logic [7:0] pass_target_pin_in,
   input wire logic [7:0] target_logic_out,
   input wire logic [7:0] target_logic_oe,
   input wire logic [7:0] pass_target_pin_out,
   input wire logic [7:0] pass_target_pin_oe,
   input wire logic [7:0] target_logic_in
);
   import sfptp_pkg::*;
   // Shadow of the mux bits, so pin checks need no peek inside
   logic [7:0] mx_r;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) mx_r <= REG_RESET;
      else if (clk_en && mem_req.wr && mem_req.addr == PASS_MUX_ADDR)
         mx_r <= mem_req.wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_mw(logic [15:0] a);
      clk_en && mem_req.wr && mem_req.addr == a;
   endsequence
   sequence s_sw(logic [7:0] a);
      clk_en && sfr_req.wr && !sfr_req.bit_wr && sfr_req.addr == a;
   endsequence
   a_pass_data: assert property (pass_target_pin_out ==
      (mx_r & pass_source_pin_in | ~mx_r & target_logic_out))
      else $error("pass data wrong");
   a_pass_dir: assert property (pass_target_pin_oe ==
      (mx_r | target_logic_oe)) else $error("target enable wrong");
   a_in_hidden: assert property (target_logic_in ==
      (~mx_r & pass_target_pin_in)) else $error("target input wrong");
   a_mux_read: assert property (clk_en && !mem_req.wr &&
      mem_req.addr == PASS_MUX_ADDR |=> mem_rdata == mx_r)
      else $error("mux read wrong");
   a_j_latch: assert property (s_sw(SFR_PORT_J_DATA_ADDR) |=>
      port_j_out == $past(sfr_req.wdata)) else $error("latch wrong");
   a_j_bitop: assert property (clk_en && sfr_req.wr && sfr_req.bit_wr &&
      (sfr_req.addr & SFR_BIT_BASE_MASK) == SFR_PORT_J_DATA_ADDR |=>
      port_j_out[$past(sfr_req.addr) % 8] == $past(sfr_req.bit_val))
      else $error("bit op wrong");
   a_j_dir: assert property (s_mw(PORT_J_DIR_ADDR) |=>
      port_j_oe == $past(mem_req.wdata)) else $error("dir j wrong");
   a_k_dir: assert property (s_mw(PORT_K_DIR_ADDR) |=>
      port_k_oe == $past(mem_req.wdata)) else $error("dir k wrong");
endmodule
bind sfptp_top sfptp_monitor sfptp_monitor_i (.clk, .resetn, .clk_en,
   .sfr_req, .mem_req, .mem_rdata, .port_j_out, .port_j_oe, .port_k_oe,
   .pass_source_pin_in, .pass_target_pin_in, .target_logic_out,
   .target_logic_oe, .pass_target_pin_out, .pass_target_pin_oe,
   .target_logic_in);
`default_nettype wire

// ===== sfptp_pkg.sv
// Package for the special-function ports and pass-through block
package sfptp_pkg;
   localparam int unsigned PORT_W = 8;
   localparam logic [7:0]  SFR_PORT_J_DATA_ADDR = 8'h80;
   localparam logic [7:0]  SFR_PORT_K_DATA_ADDR = 8'h90;
   localparam logic [15:0] PASS_MUX_ADDR        = 16'h7f85;
   localparam logic [15:0] PORT_J_DIR_ADDR      = 16'h7fad;
   localparam logic [15:0] PORT_K_DIR_ADDR      = 16'h7fae;
   localparam logic [7:0]  REG_RESET            = 8'h00;
   localparam logic [2:0]  BIT_POS_MASK         = 3'h7;
   localparam logic [7:0]  SFR_BIT_BASE_MASK    = 8'hf8;

   // Special-function space access from the microcontroller
   typedef struct packed {
      logic       wr;
      logic       bit_wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       bit_val;
   } sfptp_sfr_req_s;

   // Memory-mapped register access from the microcontroller
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sfptp_mem_req_s;
endpackage

// ===== sfptp_top.sv
// Special-function GPIO ports and the pass-through port multiplexers
//
// Operation
// - Port J data register at special-function address 0x80, resets to zero.
// - Port J direction register at 0x7fad, one means output, resets zero.
// - Port K data register at special-function address 0x90, resets to zero.
// - Port K direction register at 0x7fae, one means output, resets zero.
// - Eight pass-through ports drive target from own logic or source pin.
// - Port k pairs group G pin k-1 with group H pin k-1.
// - Pass-through mux register at 0x7f85, resets zero, bit k at D(k-1).
// - Mux bit zero leaves both pins as ordinary general pins.
// - Mux bit one drives source pin level unmodified onto target pin.
// - Only the microcontroller reaches the mux register, never the host.
// - In pass-through mode target pin is always driven as output.
// - In normal mode target direction comes only from its own bit.
// - In pass-through mode target input bit does not show the pin.
// - One address per port; writes load latch, reads return latch for output bits, pins for input bits.
// - Single-bit set and clear modify one port bit at address plus bit.
`timescale 1ns/1ps
`default_nettype none
module sfptp_top (
   // Clock, reset and enable
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire logic                    clk_en,
   // Special-function space access
   input  wire sfptp_pkg::sfptp_sfr_req_s sfr_req,
   output logic [7:0]                   sfr_rdata,
   output logic                         sfr_hit,
   // Memory-mapped register access
   input  wire sfptp_pkg::sfptp_mem_req_s mem_req,
   output logic [7:0]                   mem_rdata,
   output logic                         mem_hit,
   // Special-function port pins
   input  wire logic [7:0]              port_j_in,
   output logic [7:0]                   port_j_out,
   output logic [7:0]                   port_j_oe,
   input  wire logic [7:0]              port_k_in,
   output logic [7:0]                   port_k_out,
   output logic [7:0]                   port_k_oe,
   // Pass-through pairs
   input  wire logic [7:0]              pass_source_pin_in,
   input  wire logic [7:0]              pass_target_pin_in,
   input  wire logic [7:0]              target_logic_out,
   input  wire logic [7:0]              target_logic_oe,
   output logic [7:0]                   pass_target_pin_out,
   output logic [7:0]                   pass_target_pin_oe,
   output logic [7:0]                   target_logic_in
);
   import sfptp_pkg::*;

   logic [7:0] port_j_data_r;
   logic [7:0] port_k_data_r;
   logic [7:0] port_j_dir_r;
   logic [7:0] port_k_dir_r;
   logic [7:0] pass_through_mux_register_r;
   logic [7:0] j_s1_r, j_s2_r, j_s3_r, j_live_r;
   logic [7:0] k_s1_r, k_s2_r, k_s3_r, k_live_r;
   logic [7:0] sfr_rdata_r;
   logic [7:0] mem_rdata_r;
   logic       j_sel;
   logic       k_sel;
   logic [2:0] bit_pos;

   // Read view: latch for outputs, synchronised pin for inputs
   function automatic logic [7:0] port_view(input logic [7:0] dir,
                                            input logic [7:0] lat,
                                            input logic [7:0] pin);
      port_view = (dir & lat) | (~dir & pin);
   endfunction

   // Byte-wide write or a single-bit set or clear
   function automatic logic [7:0] port_write(input logic [7:0] cur,
                                             input sfptp_sfr_req_s rq,
                                             input logic [2:0] pos);
      logic [7:0] v;
      v = cur;
      if (rq.bit_wr) begin
         v[pos] = rq.bit_val;
      end else begin
         v = rq.wdata;
      end
      port_write = v;
   endfunction

   // Bit accesses carry address plus bit, so match the aligned base
   assign bit_pos = sfr_req.addr[2:0] & BIT_POS_MASK;
   assign j_sel   = sfr_req.bit_wr ?
      ((sfr_req.addr & SFR_BIT_BASE_MASK) == SFR_PORT_J_DATA_ADDR) :
      (sfr_req.addr == SFR_PORT_J_DATA_ADDR);
   assign k_sel   = sfr_req.bit_wr ?
      ((sfr_req.addr & SFR_BIT_BASE_MASK) == SFR_PORT_K_DATA_ADDR) :
      (sfr_req.addr == SFR_PORT_K_DATA_ADDR);

   // Three-stage pin synchronisers; the live value moves once 2 and 3 agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         j_s1_r   <= REG_RESET;
         j_s2_r   <= REG_RESET;
         j_s3_r   <= REG_RESET;
         j_live_r <= REG_RESET;
         k_s1_r   <= REG_RESET;
         k_s2_r   <= REG_RESET;
         k_s3_r   <= REG_RESET;
         k_live_r <= REG_RESET;
      end else if (clk_en) begin
         j_s1_r   <= port_j_in;
         j_s2_r   <= j_s1_r;
         j_s3_r   <= j_s2_r;
         j_live_r <= (j_s2_r & j_s3_r) | (j_live_r & (j_s2_r ^ j_s3_r));
         k_s1_r   <= port_k_in;
         k_s2_r   <= k_s1_r;
         k_s3_r   <= k_s2_r;
         k_live_r <= (k_s2_r & k_s3_r) | (k_live_r & (k_s2_r ^ k_s3_r));
      end
   end

   // Special-function output latches
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_j_data_r <= REG_RESET;
         port_k_data_r <= REG_RESET;
      end else if (clk_en && sfr_req.wr) begin
         if (j_sel) begin
            port_j_data_r <= port_write(port_j_data_r, sfr_req, bit_pos);
         end
         if (k_sel) begin
            port_k_data_r <= port_write(port_k_data_r, sfr_req, bit_pos);
         end
      end
   end

   // Memory-mapped control registers; no host path exists to them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_j_dir_r                <= REG_RESET;
         port_k_dir_r                <= REG_RESET;
         pass_through_mux_register_r <= REG_RESET;
      end else if (clk_en && mem_req.wr) begin
         unique case (mem_req.addr)
            PORT_J_DIR_ADDR: port_j_dir_r <= mem_req.wdata;
            PORT_K_DIR_ADDR: port_k_dir_r <= mem_req.wdata;
            PASS_MUX_ADDR:   pass_through_mux_register_r <= mem_req.wdata;
            default: ;
         endcase
      end
   end

   // Registered read data, one cycle after the address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata_r <= REG_RESET;
         mem_rdata_r <= REG_RESET;
      end else if (clk_en) begin
         if (sfr_req.addr == SFR_PORT_J_DATA_ADDR) begin
            sfr_rdata_r <= port_view(port_j_dir_r, port_j_data_r, j_live_r);
         end else if (sfr_req.addr == SFR_PORT_K_DATA_ADDR) begin
            sfr_rdata_r <= port_view(port_k_dir_r, port_k_data_r, k_live_r);
         end else begin
            sfr_rdata_r <= REG_RESET;
         end
         unique case (mem_req.addr)
            PORT_J_DIR_ADDR: mem_rdata_r <= port_j_dir_r;
            PORT_K_DIR_ADDR: mem_rdata_r <= port_k_dir_r;
            PASS_MUX_ADDR:   mem_rdata_r <= pass_through_mux_register_r;
            default:         mem_rdata_r <= REG_RESET;
         endcase
      end
   end

   assign sfr_rdata = sfr_rdata_r;
   assign mem_rdata = mem_rdata_r;
   assign sfr_hit   = j_sel | k_sel;
   assign mem_hit   = (mem_req.addr == PORT_J_DIR_ADDR) |
                      (mem_req.addr == PORT_K_DIR_ADDR) |
                      (mem_req.addr == PASS_MUX_ADDR);

   // Port pins: latch drives where direction says output
   assign port_j_out = port_j_data_r;
   assign port_j_oe  = port_j_dir_r;
   assign port_k_out = port_k_data_r;
   assign port_k_oe  = port_k_dir_r;

   // Pass-through: pure mux so the source edge reaches the target at once;
   // a register here would add a cycle of skew to the relayed signal
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         if (pass_through_mux_register_r[i]) begin
            pass_target_pin_out[i] = pass_source_pin_in[i];
            pass_target_pin_oe[i]  = 1'b1;
            target_logic_in[i]     = 1'b0;
         end else begin
            pass_target_pin_out[i] = target_logic_out[i];
            pass_target_pin_oe[i]  = target_logic_oe[i];
            target_logic_in[i]     = pass_target_pin_in[i];
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the port and pass-through block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sfptp_pkg::*;
   logic clk = 0, resetn = 0, clk_en = 1;
   sfptp_sfr_req_s sreq = '0;
   sfptp_mem_req_s mreq = '0;
   logic [7:0] srd, mrd, jo, joe, ko, koe, ji, ki, g, h, po, poe, tli;
   logic shit, mhit;
   logic [7:0] ej = 0, ek = 0, eg = 0, eh = 0, tlo = 0, tloe = 0;
   int num_errors = 0, cmp_count = 0, m[5] = '{default: 0}, i, v, e, o, p;
   sfptp_top sfptp_top_i (.clk, .resetn, .clk_en, .sfr_req(sreq),
      .sfr_rdata(srd), .sfr_hit(shit), .mem_req(mreq), .mem_rdata(mrd),
      .mem_hit(mhit), .port_j_in(ji), .port_j_out(jo), .port_j_oe(joe),
      .port_k_in(ki), .port_k_out(ko), .port_k_oe(koe),
      .pass_source_pin_in(g), .pass_target_pin_in(h),
      .target_logic_out(tlo), .target_logic_oe(tloe),
      .pass_target_pin_out(po), .pass_target_pin_oe(poe),
      .target_logic_in(tli));
   sfptp_board sfptp_board_i (.j_out(jo), .j_oe(joe), .k_out(ko),
      .k_oe(koe), .t_out(po), .t_oe(poe), .ext_j(ej), .ext_k(ek),
      .ext_g(eg), .ext_h(eh), .j_pin(ji), .k_pin(ki), .g_pin(g), .h_pin(h));
   always #5 clk = ~clk;
   task chk(input logic [7:0] sv, ev);
      cmp_count++;
      if (sv !== ev) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, sv, ev);
      end
   endtask
   task mw(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) mreq <= '{1'b1, a, d};
      @(posedge clk) mreq.wr <= 1'b0;
   endtask
   task mr(input logic [15:0] a, input int x);
      @(posedge clk) mreq <= '{1'b0, a, 8'h00};
      @(posedge clk) #1 chk(mrd, x[7:0]);
      chk({7'h00, mhit}, {7'h00, a == PASS_MUX_ADDR ||
         a == PORT_J_DIR_ADDR || a == PORT_K_DIR_ADDR});
   endtask
   task sw(input logic [7:0] a, d, input logic b, bv);
      @(posedge clk) sreq <= '{1'b1, b, a, d, bv};
      @(posedge clk) sreq.wr <= 1'b0;
   endtask
   task sr(input logic [7:0] a, input int x);
      @(posedge clk) sreq <= '{1'b0, 1'b0, a, 8'h00, 1'b0};
      @(posedge clk) #1 chk(srd, x[7:0]);
      chk({7'h00, shit}, {7'h00, a == SFR_PORT_J_DATA_ADDR ||
         a == SFR_PORT_K_DATA_ADDR});
   endtask
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000 num_errors++;
      complete_run;
   end
   initial begin
      v = $urandom(24);
      repeat (12) @(posedge clk);
      chk(jo | ko | joe | koe | poe, 8'h00);
      resetn <= 1'b1;
      mr(PASS_MUX_ADDR, 0);
      mr(16'h7f00, 0);
      $display("Reset test done");
      for (i = 0; i < 8; i++) begin
         v = $urandom;
         m[2] = v & 255;
         m[3] = v >> 8 & 255;
         m[4] = v >> 16 & 255;
         mw(PASS_MUX_ADDR, m[2][7:0]);
         mw(PORT_J_DIR_ADDR, m[3][7:0]);
         mw(PORT_K_DIR_ADDR, m[4][7:0]);
         mr(PASS_MUX_ADDR, m[2]);
         mr(PORT_J_DIR_ADDR, m[3]);
         mr(PORT_K_DIR_ADDR, m[4]);
         @(posedge clk) {eg, eh, tlo, tloe} <= $urandom;
         #1 e = m[2] & eg | ~m[2] & tlo;
         o = m[2] | tloe;
         p = o & e | ~o & eh;
         chk(po, e[7:0]);
         chk(poe, o[7:0]);
         chk(tli, p[7:0] & ~m[2][7:0]);
         m[0] = v & 255;
         m[1] = v >> 8 & 255;
         sw(SFR_PORT_J_DATA_ADDR, v[7:0], 1'b0, 1'b0);
         sw(SFR_PORT_K_DATA_ADDR, v[15:8], 1'b0, 1'b0);
         sw(SFR_PORT_J_DATA_ADDR + 8'(i), 8'h00, 1'b1, ~v[i]);
         sw(SFR_PORT_K_DATA_ADDR + 8'(i), 8'h00, 1'b1, 1'b1);
         m[0][i] = ~v[i];
         m[1][i] = 1;
         #1 chk(jo, m[0][7:0]);
         chk(ko, m[1][7:0]);
         @(posedge clk) {ej, ek} <= $urandom;
         repeat (8) @(posedge clk);
         sr(SFR_PORT_J_DATA_ADDR, m[0] & m[3] | ~m[3] & ej);
         sr(SFR_PORT_K_DATA_ADDR, m[1] & m[4] | ~m[4] & ek);
      end
      $display("Register and pin test done");
      @(posedge clk) clk_en <= 1'b0;
      sw(SFR_PORT_J_DATA_ADDR, ~m[0][7:0], 1'b0, 1'b0);
      mw(PASS_MUX_ADDR, ~m[2][7:0]);
      clk_en <= 1'b1;
      mr(PASS_MUX_ADDR, m[2]);
      chk(jo, m[0][7:0]);
      $display("Frozen clock test done");
      complete_run;
   end
endmodule
`default_nettype wire
